// File: src/ddcr_regs.vh
// Purpose: Constants for the disc decoder configuration register bank.
// Assumes: Offsets are register indices; the byte address is four times the index.
// Notes: Definitions only.
`ifndef DDCR_REGS_VH
`define DDCR_REGS_VH

// Register indices.
`define DDCR_IDX_CLOCK_PIN_CONTROL 5'h03
`define DDCR_IDX_LOOP_FILTER_BW 5'h08
`define DDCR_IDX_VERSATILE_FIRST 5'h0c
`define DDCR_IDX_VERSATILE_SECOND 5'h0d
`define DDCR_IDX_AUDIO_MOTOR 5'h0e
`define DDCR_IDX_SUBCODE_SHADOW 5'h0f
`define DDCR_IDX_STATUS 5'h10

// Power-on values.
`define DDCR_RST_LOOP_FILTER_BW 4'h9
`define DDCR_RST_VERSATILE_FIRST 4'h2
`define DDCR_RST_VERSATILE_SECOND 4'hf
`define DDCR_RST_AUDIO_MOTOR 4'h4
`define DDCR_RST_SUBCODE_SHADOW 4'h0
`define DDCR_RST_CLOCK_PIN_CONTROL 4'h0

// Field positions.
`define DDCR_BIT_EXT_OFF_TRACK 0
`define DDCR_BIT_SINGLE_MUTE 1
`define DDCR_BIT_PIN_THREE_LEVEL 2
`define DDCR_BIT_AUDIO_EN 2
`define DDCR_BIT_LOCK_TO_DISC 1
`define DDCR_BIT_BRAKE_LOW 0
`define DDCR_BIT_SUBCODE_ON 2
`define DDCR_BIT_SUBCODE_3W 3
`define DDCR_BIT_SHADOW_EN 0
`define DDCR_BIT_CLK_SEL_MID 0
`define DDCR_BIT_SHARED_HIZ 1
`define DDCR_BIT_FAST_HIZ 2
`define DDCR_BIT_V23_OUTPUT 3

// Versatile pin and loop filter field codes.
`define DDCR_PIN_SPECIAL 2'h1
`define DDCR_PIN_LOW 2'h2
`define DDCR_PIN_HIGH 2'h3
`define DDCR_FOUR_LINE_MOTOR 4'h0
`define DDCR_BW_UNDEFINED 2'h3

// Decoded targets.
`define DDCR_SEL_NONE 3'h0
`define DDCR_SEL_LOOP 3'h1
`define DDCR_SEL_VFIRST 3'h2
`define DDCR_SEL_VSECOND 3'h3
`define DDCR_SEL_AUDIO 3'h4
`define DDCR_SEL_SUBSH 3'h5
`define DDCR_SEL_CLKPIN 3'h6
`define DDCR_SEL_STATUS 3'h7

// Bus responses.
`define DDCR_RESP_OKAY 2'h0
`define DDCR_RESP_SLVERR 2'h2

`endif

// File: src/ddcr_config_regs.v
// Purpose: AXI4-Lite bank of the four-bit decoder and shadow configuration registers.
// Assumes: Pin inputs are synchronous to aclk; one write and one read in flight at most.
// Notes: Only the low nibble of each word carries data; upper bits read as zero.
// Operation
// - Register C bit 0 picks external off-track from pin one, else internal.
// - Register C bits 2..1 route left/right mute or single mute with pin three level.
// - Register D bits 1..0 put subcode, low or high on pin four.
// - Register D bits 3..2 put de-emphasis flag, low or high on pin five.
// - Register D value zero turns pins four and five into motor lines.
// - Shadow enable set routes following addresses to the shadow set.
// - Shadow enable clear decodes normal registers; shadows unreachable.
// - Register 8 selects loop filter bandwidth; low bits 11 undefined.
// - Reset loads every register field with its power-on value.
// - Shadow 3 bit 0 chooses slow or mid clock on shared pin.
// - Shadow 3 bit 1 drives or floats the shared clock pin.
// - Shadow 3 bit 2 drives or floats the fast clock pin.
// - Shadow 3 bit 3 makes shared pin input two or open-drain output three.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "ddcr_regs.vh"

module ddcr_config_regs (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire versatile_pin_one,
  input wire versatile_pin_two,
  input wire internal_off_track,
  input wire mute_left,
  input wire mute_right,
  input wire subcode_serial,
  input wire deemph_flag,
  input wire motor_line_a,
  input wire motor_line_b,
  input wire slow_clock_src,
  input wire mid_clock_src,
  input wire fast_clock_src,
  output reg off_track,
  output reg mute_pin,
  output reg versatile_pin_three_out,
  output reg versatile_pin_three_oe,
  output reg versatile_pin_four,
  output reg versatile_pin_five,
  output reg deemph_filter_bypass,
  output reg motor_four_line,
  output reg shared_clock_pin_out,
  output reg shared_clock_pin_oe,
  output reg fast_clock_pin_out,
  output reg fast_clock_pin_oe,
  output reg [3:0] loop_bw_code,
  output reg audio_features_en,
  output reg lock_to_disc_en,
  output reg brake_six_percent,
  output reg subcode_if_on,
  output reg subcode_three_wire,
  output reg shadow_active
);

  // Stored register nibbles.
  reg [3:0] loop_filter_bandwidth;
  reg [3:0] versatile_pins_first;
  reg [3:0] versatile_pins_second;
  reg [3:0] audio_motor_options;
  reg [3:0] subcode_and_shadow_enable;
  reg [3:0] clock_pin_control;

  // Captured write halves.
  reg aw_got;
  reg w_got;
  reg [4:0] aw_index;
  reg [3:0] w_nibble;
  reg w_lane;

  wire shadow_select_bit;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire [3:0] status_word;
  reg pin_three_level;
  reg [1:0] pin_four_mode;
  reg [1:0] pin_five_mode;

  // Address decode shared by both channels; the mode bit decides which set is seen.
  function [2:0] fn_decode;
    input [4:0] idx;
    input shadow;
    begin
      fn_decode = `DDCR_SEL_NONE;
      if (idx == `DDCR_IDX_STATUS)
        fn_decode = `DDCR_SEL_STATUS;
      // Index F stays reachable in both modes so software can leave shadow mode.
      else if (idx == `DDCR_IDX_SUBCODE_SHADOW)
        fn_decode = `DDCR_SEL_SUBSH;
      else if (shadow)
      begin
        if (idx == `DDCR_IDX_CLOCK_PIN_CONTROL)
          fn_decode = `DDCR_SEL_CLKPIN;
      end
      else
      begin
        case (idx)
          `DDCR_IDX_LOOP_FILTER_BW: fn_decode = `DDCR_SEL_LOOP;
          `DDCR_IDX_VERSATILE_FIRST: fn_decode = `DDCR_SEL_VFIRST;
          `DDCR_IDX_VERSATILE_SECOND: fn_decode = `DDCR_SEL_VSECOND;
          `DDCR_IDX_AUDIO_MOTOR: fn_decode = `DDCR_SEL_AUDIO;
          default: fn_decode = `DDCR_SEL_NONE;
        endcase
      end
    end
  endfunction

  assign shadow_select_bit = subcode_and_shadow_enable[`DDCR_BIT_SHADOW_EN];
  assign wr_sel = fn_decode(aw_index, shadow_select_bit);
  assign rd_sel = fn_decode(s_axi_araddr[6:2], shadow_select_bit);

  // Status shows live pin levels, the mode bit and an undefined filter code.
  assign status_word = {
    (loop_filter_bandwidth[1:0] == `DDCR_BW_UNDEFINED),
    shadow_select_bit,
    versatile_pin_two,
    versatile_pin_one
  };

  // Write channel: address and data are taken in either order, then committed.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DDCR_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_index <= 5'h00;
      w_nibble <= 4'h0;
      w_lane <= 1'b0;
      loop_filter_bandwidth <= `DDCR_RST_LOOP_FILTER_BW;
      versatile_pins_first <= `DDCR_RST_VERSATILE_FIRST;
      versatile_pins_second <= `DDCR_RST_VERSATILE_SECOND;
      audio_motor_options <= `DDCR_RST_AUDIO_MOTOR;
      subcode_and_shadow_enable <= `DDCR_RST_SUBCODE_SHADOW;
      clock_pin_control <= `DDCR_RST_CLOCK_PIN_CONTROL;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_index <= s_axi_awaddr[6:2];
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_nibble <= s_axi_wdata[3:0];
        w_lane <= s_axi_wstrb[0];
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (aw_got && w_got)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DDCR_RESP_OKAY;
        if (w_lane)
        begin
          case (wr_sel)
            `DDCR_SEL_LOOP: loop_filter_bandwidth <= w_nibble;
            `DDCR_SEL_VFIRST: versatile_pins_first <= w_nibble;
            `DDCR_SEL_VSECOND: versatile_pins_second <= w_nibble;
            `DDCR_SEL_AUDIO: audio_motor_options <= w_nibble;
            `DDCR_SEL_SUBSH: subcode_and_shadow_enable <= w_nibble;
            `DDCR_SEL_CLKPIN: clock_pin_control <= w_nibble;
            default: s_axi_bresp <= `DDCR_RESP_SLVERR;
          endcase
        end
        if (wr_sel == `DDCR_SEL_NONE || wr_sel == `DDCR_SEL_STATUS)
          s_axi_bresp <= `DDCR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data are formed at the address handshake and held until taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DDCR_RESP_OKAY;
    end
    else if (s_axi_arready && s_axi_arvalid)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DDCR_RESP_OKAY;
      case (rd_sel)
        `DDCR_SEL_LOOP: s_axi_rdata <= {28'h0000000, loop_filter_bandwidth};
        `DDCR_SEL_VFIRST: s_axi_rdata <= {28'h0000000, versatile_pins_first};
        `DDCR_SEL_VSECOND: s_axi_rdata <= {28'h0000000, versatile_pins_second};
        `DDCR_SEL_AUDIO: s_axi_rdata <= {28'h0000000, audio_motor_options};
        `DDCR_SEL_SUBSH: s_axi_rdata <= {28'h0000000, subcode_and_shadow_enable};
        `DDCR_SEL_CLKPIN: s_axi_rdata <= {28'h0000000, clock_pin_control};
        `DDCR_SEL_STATUS: s_axi_rdata <= {28'h0000000, status_word};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `DDCR_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Field decode for the versatile pins.
  always @*
  begin
    pin_three_level = versatile_pins_first[`DDCR_BIT_PIN_THREE_LEVEL];
    pin_four_mode = versatile_pins_second[1:0];
    pin_five_mode = versatile_pins_second[3:2];
    if (!versatile_pins_first[`DDCR_BIT_SINGLE_MUTE])
      pin_three_level = mute_right;
  end

  // Pin and control outputs, all registered so they stay glitch free.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      off_track <= 1'b0;
      mute_pin <= 1'b0;
      versatile_pin_three_out <= 1'b0;
      versatile_pin_three_oe <= 1'b0;
      versatile_pin_four <= 1'b1;
      versatile_pin_five <= 1'b1;
      deemph_filter_bypass <= 1'b0;
      motor_four_line <= 1'b0;
      shared_clock_pin_out <= 1'b0;
      shared_clock_pin_oe <= 1'b0;
      fast_clock_pin_out <= 1'b0;
      fast_clock_pin_oe <= 1'b0;
      loop_bw_code <= `DDCR_RST_LOOP_FILTER_BW;
      audio_features_en <= 1'b0;
      lock_to_disc_en <= 1'b0;
      brake_six_percent <= 1'b0;
      subcode_if_on <= 1'b0;
      subcode_three_wire <= 1'b0;
      shadow_active <= 1'b0;
    end
    else
    begin
      off_track <= versatile_pins_first[`DDCR_BIT_EXT_OFF_TRACK] ?
        versatile_pin_one : internal_off_track;
      // mute routing; single mode mutes only when both channels ask.
      mute_pin <= versatile_pins_first[`DDCR_BIT_SINGLE_MUTE] ?
        (mute_left & mute_right) : mute_left;
      // open-drain pin three pulls low only, and only in output mode.
      versatile_pin_three_out <= 1'b0;
      versatile_pin_three_oe <= clock_pin_control[`DDCR_BIT_V23_OUTPUT] & ~pin_three_level;
      motor_four_line <= (versatile_pins_second == `DDCR_FOUR_LINE_MOTOR);
      case (pin_four_mode)
        `DDCR_PIN_SPECIAL: versatile_pin_four <= subcode_serial;
        `DDCR_PIN_LOW: versatile_pin_four <= 1'b0;
        `DDCR_PIN_HIGH: versatile_pin_four <= 1'b1;
        default: versatile_pin_four <= motor_line_a;
      endcase
      case (pin_five_mode)
        `DDCR_PIN_SPECIAL: versatile_pin_five <= deemph_flag;
        `DDCR_PIN_LOW: versatile_pin_five <= 1'b0;
        `DDCR_PIN_HIGH: versatile_pin_five <= 1'b1;
        default: versatile_pin_five <= motor_line_b;
      endcase
      deemph_filter_bypass <= (pin_five_mode == `DDCR_PIN_SPECIAL);
      shared_clock_pin_out <= clock_pin_control[`DDCR_BIT_CLK_SEL_MID] ?
        mid_clock_src : slow_clock_src;
      shared_clock_pin_oe <= ~clock_pin_control[`DDCR_BIT_SHARED_HIZ];
      fast_clock_pin_out <= fast_clock_src;
      fast_clock_pin_oe <= ~clock_pin_control[`DDCR_BIT_FAST_HIZ];
      loop_bw_code <= loop_filter_bandwidth;
      audio_features_en <= audio_motor_options[`DDCR_BIT_AUDIO_EN];
      lock_to_disc_en <= audio_motor_options[`DDCR_BIT_LOCK_TO_DISC];
      brake_six_percent <= audio_motor_options[`DDCR_BIT_BRAKE_LOW];
      subcode_if_on <= subcode_and_shadow_enable[`DDCR_BIT_SUBCODE_ON];
      subcode_three_wire <= subcode_and_shadow_enable[`DDCR_BIT_SUBCODE_3W];
      shadow_active <= shadow_select_bit;
    end
  end

endmodule // ddcr_config_regs

// File: testbench/ddcr_pin_partner.sv
// Purpose: Far-side pin sources for the configuration bank.
// Assumes: Every source is a level synchronous to aclk.
// Notes: Pin one and the internal off-track flag are always opposite, so a wrong pick shows.
`timescale 1ns/1ns

module ddcr_pin_partner (
  input wire aclk,
  output wire versatile_pin_one,
  output wire versatile_pin_two,
  output wire internal_off_track,
  output wire mute_left,
  output wire mute_right,
  output wire subcode_serial,
  output wire deemph_flag,
  output wire motor_line_a,
  output wire motor_line_b,
  output wire slow_clock_src,
  output wire mid_clock_src,
  output wire fast_clock_src
);
  logic [6:0] c = 7'h00;

  // Free count; distinct bit mixes keep most sources apart, but motor line B and the mid clock both follow count bit 1.
  always @(posedge aclk)
  begin
    c <= c + 7'h01;
  end

  // Levels and clocks seen at the device pins.
  assign versatile_pin_one = c[3];
  assign internal_off_track = ~c[3];
  assign versatile_pin_two = c[6];
  assign mute_left = c[4];
  assign mute_right = c[5] ^ c[2];
  assign subcode_serial = c[2] ^ c[4];
  assign deemph_flag = c[5] ^ c[3];
  assign motor_line_a = c[3] ^ c[6];
  assign motor_line_b = c[1];
  assign slow_clock_src = c[2];
  assign mid_clock_src = c[1];
  assign fast_clock_src = c[0];
endmodule // ddcr_pin_partner

// File: testbench/ddcr_config_regs_props.sv
// Purpose: Concurrent checks on the configuration bank's bus and pin ports.
// Assumes: One clock aclk; synchronous active-low aresetn.
// Notes: Pin outputs are registered one cycle behind their sources.
`timescale 1ns/1ns

module ddcr_config_regs_props (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire motor_line_a,
  input wire motor_line_b,
  input wire deemph_flag,
  input wire fast_clock_src,
  input wire versatile_pin_three_out,
  input wire versatile_pin_three_oe,
  input wire versatile_pin_four,
  input wire versatile_pin_five,
  input wire deemph_filter_bypass,
  input wire motor_four_line,
  input wire fast_clock_pin_out,
  input wire shadow_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fast_clock_follow: assert property ($past(aresetn)
    |-> fast_clock_pin_out == $past(fast_clock_src))
    else $error("fast clock pin does not follow its source");
  a_motor_lines_out: assert property (motor_four_line
    |-> versatile_pin_four == $past(motor_line_a) && versatile_pin_five == $past(motor_line_b))
    else $error("motor lines not on pins four and five");
  a_deemph_on_five: assert property (deemph_filter_bypass
    |-> versatile_pin_five == $past(deemph_flag))
    else $error("de-emphasis flag not on pin five");
  a_pin_three_drain: assert property (versatile_pin_three_oe
    |-> versatile_pin_three_out == 1'b0)
    else $error("pin three drives high");
  a_write_answer_time: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:4] == 28'h0)
    else $error("read answer late or upper bits set");
  a_write_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_shadow_refuse: assert property (shadow_active && s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && s_axi_awaddr[6:2] == 5'h0c |-> ##2 s_axi_bresp == 2'h2)
    else $error("normal register written in shadow mode");
  a_normal_refuse: assert property (!shadow_active && s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && s_axi_awaddr[6:2] == 5'h03 |-> ##2 s_axi_bresp == 2'h2)
    else $error("shadow register written in normal mode");
endmodule // ddcr_config_regs_props

bind ddcr_config_regs ddcr_config_regs_props u_props (.*);

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the configuration bank over AXI4-Lite.
// Assumes: The partner model drives every pin source.
// Notes: Pin checks compare against sources sampled one edge earlier.
`timescale 1ns/1ns

module tb_top;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire versatile_pin_one, versatile_pin_two, internal_off_track, mute_left, mute_right;
  wire subcode_serial, deemph_flag, motor_line_a, motor_line_b;
  wire slow_clock_src, mid_clock_src, fast_clock_src;
  wire off_track, mute_pin, versatile_pin_three_out, versatile_pin_three_oe, versatile_pin_four;
  wire versatile_pin_five, deemph_filter_bypass, motor_four_line, shared_clock_pin_out;
  wire shared_clock_pin_oe, fast_clock_pin_out, fast_clock_pin_oe, audio_features_en;
  wire lock_to_disc_en, brake_six_percent, subcode_if_on, subcode_three_wire, shadow_active;
  wire [3:0] loop_bw_code;
  logic [7:0] pv;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int i;

  ddcr_config_regs u_dut (.*);
  ddcr_pin_partner u_partner (.*);

  always #5 aclk = ~aclk;

  // Sources as the design saw them at the last edge; outputs lag one cycle.
  always @(posedge aclk)
  begin
    pv <= {versatile_pin_one, internal_off_track, mute_left, mute_right, subcode_serial,
      deemph_flag, mid_clock_src, slow_clock_src};
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      $display("ERROR %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let the new register value reach the pins, then look at mid-cycle.
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  // A write always carries a whole nibble; the channels may be taken apart.
  task automatic wr(input logic [31:0] a, input logic [3:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (s_axi_awready && !ad)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    // Status pins are live levels; take them as the design saw them at the address handshake.
    if (a == 32'h40)
      e[1:0] = {versatile_pin_two, versatile_pin_one};
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, r);
    chk(s_axi_rdata, e);
  endtask

  // Main sequence: reset, decoder registers, then the shadow set.
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h20, 32'h9, 2'h0);
    rd(32'h30, 32'h2, 2'h0);
    rd(32'h34, 32'hf, 2'h0);
    rd(32'h38, 32'h4, 2'h0);
    rd(32'h3c, 32'h0, 2'h0);
    settle();
    chk({audio_features_en, lock_to_disc_en, brake_six_percent, shadow_active}, 4'h8);
    chk({versatile_pin_four, versatile_pin_five}, 2'h3);
    chk({shared_clock_pin_oe, fast_clock_pin_oe}, 2'h3);
    chk(shared_clock_pin_out, pv[0]);
    wr(32'h30, 4'h1, 2'h0);
    settle();
    chk(off_track, pv[7]);
    wr(32'h30, 4'h0, 2'h0);
    settle();
    chk({off_track, mute_pin}, {pv[6], pv[5]});
    wr(32'h30, 4'h2, 2'h0);
    settle();
    chk(mute_pin, pv[5] & pv[4]);
    wr(32'h34, 4'h1, 2'h0);
    settle();
    chk(versatile_pin_four, pv[3]);
    wr(32'h34, 4'h6, 2'h0);
    settle();
    chk({versatile_pin_four, versatile_pin_five}, {1'b0, pv[2]});
    chk(deemph_filter_bypass, 1'b1);
    wr(32'h34, 4'hb, 2'h0);
    settle();
    chk({versatile_pin_four, versatile_pin_five}, 2'h2);
    chk({deemph_filter_bypass, motor_four_line}, 2'h0);
    wr(32'h34, 4'h0, 2'h0);
    settle();
    chk(motor_four_line, 1'b1);
    wr(32'h38, 4'hb, 2'h0);
    wr(32'h3c, 4'hc, 2'h0);
    // A write with the low byte lane off is answered but stores nothing.
    s_axi_wstrb <= 4'he;
    wr(32'h38, 4'h4, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(32'h38, 32'hb, 2'h0);
    settle();
    chk({audio_features_en, lock_to_disc_en, brake_six_percent}, 3'h3);
    chk({subcode_if_on, subcode_three_wire, shadow_active}, 3'h6);
    for (i = 0; i < 16; i++)
    begin
      wr(32'h20, i[3:0], 2'h0);
      rd(32'h20, i, 2'h0);
    end
    settle();
    chk(loop_bw_code, 4'hf);
    rd(32'h40, 32'h8, 2'h0);
    wr(32'h04, 4'h5, 2'h2);
    rd(32'h04, 32'h0, 2'h2);
    wr(32'h40, 4'h5, 2'h2);
    wr(32'h0c, 4'h1, 2'h2);
    wr(32'h3c, 4'h1, 2'h0);
    rd(32'h40, 32'hc, 2'h0);
    wr(32'h30, 4'h5, 2'h2);
    rd(32'h30, 32'h0, 2'h2);
    wr(32'h0c, 4'he, 2'h0);
    rd(32'h0c, 32'he, 2'h0);
    settle();
    chk({shared_clock_pin_oe, fast_clock_pin_oe, versatile_pin_three_oe}, 3'h1);
    wr(32'h0c, 4'h1, 2'h0);
    settle();
    chk({shared_clock_pin_out, shared_clock_pin_oe, fast_clock_pin_oe}, {pv[1], 2'b11});
    chk(versatile_pin_three_oe, 1'b0);
    wr(32'h3c, 4'h0, 2'h0);
    wr(32'h0c, 4'h0, 2'h2);
    rd(32'h30, 32'h2, 2'h0);
    // Split mutes: pin three pulls low while the right mute is clear.
    wr(32'h30, 4'h0, 2'h0);
    wr(32'h3c, 4'h1, 2'h0);
    wr(32'h0c, 4'h8, 2'h0);
    settle();
    chk(versatile_pin_three_oe, !pv[4]);
    // Single mute with pin three set high: the open-drain pin lets go.
    wr(32'h3c, 4'h0, 2'h0);
    wr(32'h30, 4'h6, 2'h0);
    settle();
    chk(versatile_pin_three_oe, 1'b0);
    final_report();
  end
endmodule // tb_top
